/* design/rtc_pin_side_cfg.svh */
// Constants for the real-time clock pin-side control block: offsets,
// field positions, reset values and the rate-select lookup table.
// Assumes it is included by bare name from design files only.
`ifndef RTC_PIN_SIDE_CFG_SVH
`define RTC_PIN_SIDE_CFG_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define EXT_CTRL_ADDR      8'h4B
`define EXT_CTRL_RESET     8'h00
`define RAM_BASE_ADDR      8'h0E
`define RAM_LAST_ADDR      8'h7F
`define RAM_BANK1_LAST     8'h3F
`define RAM_BYTES          114
`define RAM_CLEAR_VALUE    8'hFF
`define UNMAPPED_READ      8'h00

// ----------------------------------------------------------------
// extended control fields (bit positions)
// ----------------------------------------------------------------
`define AUX_SUPPLY_EN_BIT  7
`define EN_32KHZ_BIT       5
`define KS_IRQ_EN_BIT      4
`define KS_FLAG_BIT        0
`define EXT_CTRL_WR_MASK   8'hB0

// ----------------------------------------------------------------
// square-wave divider
// ----------------------------------------------------------------
`define DIV_STAGES         15
// one nibble per rate code, code 0 in the low nibble; F means no output
`define RATE_TAP_TABLE     64'hDCBA_9876_5432_1FFF
`define TAP_NONE           4'hF

`endif

/* design/rtc_pin_side_control.sv */
// Pin-side control of a battery-backed real-time clock: read buffer
// enable, open-drain interrupt and power-on pins, kickstart input,
// general-purpose RAM with clear input, square-wave output, and access
// inhibit below the power-fail trip point.
// Assumes the address phase is demultiplexed outside and i_addr holds
// the latched address; all pins are synchronous to i_clock.
//
// Behaviour
// - drive data only while read strobe low
// - kickstart fall without main power powers on
// - kickstart is interrupt while main power on
// - irq low while enabled flag set
// - irq undriven when nothing pending
// - ram clear sets general RAM to ones
// - ram clear works on any supply
// - power rise sets divider bit, 32k enable
// - wave runs on main power when either enable set
// - 32k enable overrides rate select
// - frequency from thirteen of fifteen divider taps
// - unpowered 32k needs enable, aux enable, aux
// - disabled and unpowered wave is high impedance
// - bus ignored below power-fail trip point
// - 32k and aux enables live at 4Bh
// - power-on pin by kickstart or wake-up
`timescale 1ns/1ps
`include "rtc_pin_side_cfg.svh"
module rtc_pin_side_control
  import rtc_pin_side_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic       i_power_fail_trip,
  input  wire logic       i_aux_supply,
  input  wire logic       i_cs_n,
  input  wire logic       i_rd_n,
  input  wire logic       i_wr_n,
  input  wire logic       i_bank1,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_data,
  output logic            o_data_oe_n,
  input  wire logic       i_kickstart_n,
  input  wire logic       i_wakeup_irq,
  input  wire logic       i_power_off_req,
  output logic            o_power_on_out_n,
  output logic            o_power_on_oe_n,
  input  wire logic [5:0] i_irq_flags,
  input  wire logic [5:0] i_irq_enables,
  output logic            o_irq_out_n,
  output logic            o_irq_oe_n,
  input  wire logic       i_ram_clear_n,
  input  wire logic       i_osc_tick,
  input  wire logic       i_square_wave_enable,
  input  wire logic [3:0] i_rate_select,
  output logic            o_divider_ctrl_bit1_set,
  output logic            o_square_wave_out,
  output logic            o_square_wave_oe_n
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic ram_hit(input logic [7:0] addr, input logic bank1);
    logic [7:0] last;
    last    = bank1 ? `RAM_BANK1_LAST : `RAM_LAST_ADDR;
    ram_hit = (addr >= `RAM_BASE_ADDR) && (addr <= last);
  endfunction

  function automatic logic ext_hit(input logic [7:0] addr, input logic bank1);
    ext_hit = bank1 && (addr == `EXT_CTRL_ADDR);
  endfunction

  // ----------------------------------------------------------------
  // power state
  // ----------------------------------------------------------------
  power_state_t pwr_q;
  power_state_t pwr_d;
  logic         accessible;
  logic         power_rise;

  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      PWR_DOWN: begin
        if (i_power_fail_trip) begin
          pwr_d = PWR_RISE;
        end
      end
      PWR_RISE: begin
        pwr_d = i_power_fail_trip ? PWR_UP : PWR_DOWN;
      end
      PWR_UP: begin
        if (!i_power_fail_trip) begin
          pwr_d = PWR_DOWN;
        end
      end
      default: begin
        pwr_d = PWR_DOWN;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pwr_q <= PWR_DOWN;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  assign accessible = (pwr_q == PWR_UP) && i_power_fail_trip;
  assign power_rise = (pwr_q == PWR_RISE);

  // ----------------------------------------------------------------
  // bus strobes
  // ----------------------------------------------------------------
  logic       wr_n_q;
  logic       wr_n_d;
  logic [7:0] wdata_q;
  logic [7:0] wdata_d;
  logic       ks_n_q;
  logic       ks_n_d;
  logic       wr_take;
  logic       ks_fall;

  always_comb begin
    wr_n_d  = i_wr_n;
    ks_n_d  = i_kickstart_n;
    wdata_d = wdata_q;
    // capture data while the strobe is low; the rising edge commits it
    if (!i_wr_n) begin
      wdata_d = i_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_n_q  <= 1'b1;
      ks_n_q  <= 1'b1;
      wdata_q <= 8'h00;
    end else begin
      wr_n_q  <= wr_n_d;
      ks_n_q  <= ks_n_d;
      wdata_q <= wdata_d;
    end
  end

  assign wr_take = !wr_n_q && i_wr_n && !i_cs_n && accessible;
  assign ks_fall = ks_n_q && !i_kickstart_n;

  // ----------------------------------------------------------------
  // extended control register
  // ----------------------------------------------------------------
  byte_t ext_q;
  byte_t ext_d;

  always_comb begin
    ext_d = ext_q;
    if (wr_take && ext_hit(i_addr, i_bank1)) begin
      ext_d = (ext_q & ~`EXT_CTRL_WR_MASK) | (wdata_q & `EXT_CTRL_WR_MASK);
      // the flag clears by writing zero; a one leaves it alone
      if (!wdata_q[`KS_FLAG_BIT]) begin
        ext_d[`KS_FLAG_BIT] = 1'b0;
      end
    end
    if (power_rise) begin
      ext_d[`EN_32KHZ_BIT] = 1'b1;
    end
    // kickstart as interrupt; set wins over clear
    if (ks_fall && i_power_fail_trip) begin
      ext_d[`KS_FLAG_BIT] = 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_q <= `EXT_CTRL_RESET;
    end else begin
      ext_q <= ext_d;
    end
  end

  // ----------------------------------------------------------------
  // general-purpose RAM
  // ----------------------------------------------------------------
  byte_t      ram_q [`RAM_BYTES];
  byte_t      ram_d [`RAM_BYTES];
  logic [6:0] ram_idx;
  logic       ram_wr;

  assign ram_idx = 7'(i_addr - `RAM_BASE_ADDR);
  assign ram_wr  = wr_take && ram_hit(i_addr, i_bank1);

  genvar g;
  generate
    for (g = 0; g < `RAM_BYTES; g = g + 1) begin : gen_ram
      always_comb begin
        ram_d[g] = ram_q[g];
        if (!i_ram_clear_n) begin
          ram_d[g] = `RAM_CLEAR_VALUE;
        end else if (ram_wr && (ram_idx == 7'(g))) begin
          ram_d[g] = wdata_q;
        end
      end

      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          ram_q[g] <= `RAM_CLEAR_VALUE;
        end else begin
          ram_q[g] <= ram_d[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  byte_t rdata_q;
  byte_t rdata_d;

  always_comb begin
    rdata_d = `UNMAPPED_READ;
    if (ext_hit(i_addr, i_bank1)) begin
      rdata_d = ext_q;
    end else if (ram_hit(i_addr, i_bank1)) begin
      rdata_d = ram_q[ram_idx];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_data = rdata_q;
  assign o_data_oe_n = !(!i_rd_n && !i_cs_n && accessible);

  // ----------------------------------------------------------------
  // interrupt and power-on pins
  // ----------------------------------------------------------------
  logic irq_oe_n_q;
  logic irq_oe_n_d;
  logic pwr_on_q;
  logic pwr_on_d;
  logic pending;

  always_comb begin
    pending = |(i_irq_flags & i_irq_enables)
            | (ext_q[`KS_FLAG_BIT] & ext_q[`KS_IRQ_EN_BIT]);
    irq_oe_n_d = !pending;
    pwr_on_d   = pwr_on_q;
    if (i_power_off_req) begin
      pwr_on_d = 1'b0;
    end
    if (!i_power_fail_trip && (ks_fall || i_wakeup_irq)) begin
      pwr_on_d = 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_oe_n_q <= 1'b1;
      pwr_on_q   <= 1'b0;
    end else begin
      irq_oe_n_q <= irq_oe_n_d;
      pwr_on_q   <= pwr_on_d;
    end
  end

  assign o_irq_out_n      = 1'b0;
  assign o_irq_oe_n       = irq_oe_n_q;
  assign o_power_on_out_n = 1'b0;
  assign o_power_on_oe_n  = !pwr_on_q;

  // ----------------------------------------------------------------
  // square-wave output
  // ----------------------------------------------------------------
  logic dv1_q;
  logic wave_enable;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dv1_q <= 1'b0;
    end else begin
      dv1_q <= power_rise;
    end
  end

  assign o_divider_ctrl_bit1_set = dv1_q;

  always_comb begin
    if (i_power_fail_trip) begin
      wave_enable = i_square_wave_enable || ext_q[`EN_32KHZ_BIT];
    end else begin
      // unpowered needs aux enable and aux
      wave_enable = ext_q[`EN_32KHZ_BIT] && ext_q[`AUX_SUPPLY_EN_BIT] && i_aux_supply;
    end
  end

  rtc_square_wave_gen u_wave (
    .i_clock        (i_clock),
    .i_rst_n        (i_rst_n),
    .i_osc_tick     (i_osc_tick),
    .i_rate_select  (i_rate_select),
    .i_sel_32k      (ext_q[`EN_32KHZ_BIT]),
    .i_enable       (wave_enable),
    .i_hiz_when_off (!i_power_fail_trip),
    .o_wave         (o_square_wave_out),
    .o_wave_oe_n    (o_square_wave_oe_n)
  );

endmodule

/* design/rtc_pin_side_pkg.sv */
// Types shared by the pin-side control block.
// Assumes nothing of its surroundings.
package rtc_pin_side_pkg;

  // gray-coded along down -> rise -> up
  typedef enum logic [1:0] {
    PWR_DOWN = 2'b00,
    PWR_RISE = 2'b01,
    PWR_UP   = 2'b11
  } power_state_t;

  typedef logic [7:0] byte_t;

endpackage

/* design/rtc_square_wave_gen.sv */
// Square-wave generator: fifteen-stage divider on the oscillator tick,
// tap selection by rate code, registered output and output enable.
// Assumes i_osc_tick pulses once per oscillator half period.
`timescale 1ns/1ps
`include "rtc_pin_side_cfg.svh"
module rtc_square_wave_gen
  import rtc_pin_side_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic       i_osc_tick,
  input  wire logic [3:0] i_rate_select,
  input  wire logic       i_sel_32k,
  input  wire logic       i_enable,
  input  wire logic       i_hiz_when_off,
  output logic            o_wave,
  output logic            o_wave_oe_n
);

  logic [`DIV_STAGES-1:0] div_q;
  logic [`DIV_STAGES-1:0] div_d;
  logic                   wave_q;
  logic                   wave_d;
  logic                   oe_n_q;
  logic                   oe_n_d;
  logic [3:0]             tap;
  logic [`DIV_STAGES:0]   div_ext;

  function automatic logic [3:0] tap_for_code(input logic [3:0] code);
    logic [63:0] table_v;
    table_v = `RATE_TAP_TABLE;
    tap_for_code = table_v[{code, 2'b00} +: 4];
  endfunction

  always_comb begin
    div_d   = div_q;
    tap     = tap_for_code(i_rate_select);
    div_ext = {1'b0, div_q};
    if (i_osc_tick) begin
      div_d = div_q + `DIV_STAGES'(1);
    end
    if (!i_enable) begin
      wave_d = 1'b0;
    end else if (i_sel_32k) begin
      wave_d = div_q[0];
    end else if (tap == `TAP_NONE) begin
      wave_d = 1'b0;
    end else begin
      wave_d = div_ext[tap];
    end
    oe_n_d = !i_enable && i_hiz_when_off;
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q  <= '0;
      wave_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      div_q  <= div_d;
      wave_q <= wave_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign o_wave      = wave_q;
  assign o_wave_oe_n = oe_n_q;

endmodule

/* tb/rtc_host.sv */
// Host processor model: byte-wide bus cycles on the split bus legs.
// Assumes the bench calls its tasks; signals move at the falling edge.
`timescale 1ns/1ps
module rtc_host (
  input  wire logic       i_clock,
  input  wire logic [7:0] i_rd_data,
  input  wire logic       i_data_oe_n,
  output logic            o_cs_n,
  output logic            o_rd_n,
  output logic            o_wr_n,
  output logic            o_bank1,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_data
);
  initial begin
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_bank1 = 1'b0;
    o_addr = 8'h00;
    o_data = 8'h00;
  end
  // commit happens at the edge that sees the strobe high again
  task automatic write(input logic b, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clock);
    o_cs_n = 1'b0;
    o_wr_n = 1'b0;
    o_bank1 = b;
    o_addr = a;
    o_data = d;
    @(negedge i_clock);
    o_wr_n = 1'b1;
    @(negedge i_clock);
    o_cs_n = 1'b1;
    // released leg carries the inverse, never the stale byte
    o_data = ~d;
  endtask
  task automatic read(input logic b, input logic [7:0] a, output logic [7:0] d,
                      output logic oe_n);
    @(negedge i_clock);
    o_cs_n = 1'b0;
    o_rd_n = 1'b0;
    o_bank1 = b;
    o_addr = a;
    @(negedge i_clock);
    // an undriven bus reads back as the inverse, so a stale byte cannot pass
    d = i_data_oe_n ? ~i_rd_data : i_rd_data;
    oe_n = i_data_oe_n;
    o_rd_n = 1'b1;
    o_cs_n = 1'b1;
  endtask
endmodule

/* tb/rtc_pin_side_control_asserts.sv */
// Port-level assertions for the pin-side control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module rtc_pin_side_control_asserts (
  input wire logic       i_clock,
  input wire logic       i_rst_n,
  input wire logic       i_power_fail_trip,
  input wire logic       i_aux_supply,
  input wire logic       i_cs_n,
  input wire logic       i_rd_n,
  input wire logic       i_kickstart_n,
  input wire logic [5:0] i_irq_flags,
  input wire logic [5:0] i_irq_enables,
  input wire logic       o_data_oe_n,
  input wire logic       o_irq_oe_n,
  input wire logic       o_power_on_oe_n,
  input wire logic       o_divider_ctrl_bit1_set,
  input wire logic       o_square_wave_out,
  input wire logic       o_square_wave_oe_n
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------------------------------
  // pin relations
  // ----------------------------------------------------------------
  property p_rd_drive;
    !o_data_oe_n |-> !i_rd_n && !i_cs_n && i_power_fail_trip;
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("bus driven without read");
  // access needs two edges of stable power first
  property p_rise_inhibit;
    $rose(i_power_fail_trip) |-> o_data_oe_n [*2];
  endproperty
  a_rise_inhibit: assert property (p_rise_inhibit) else $error("early bus access");
  property p_irq_set;
    |(i_irq_flags & i_irq_enables) |=> !o_irq_oe_n;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq not asserted");
  property p_irq_free;
    $rose(o_irq_oe_n) |-> $past(~|(i_irq_flags & i_irq_enables));
  endproperty
  a_irq_free: assert property (p_irq_free) else $error("irq released early");
  property p_kick;
    !i_power_fail_trip && $fell(i_kickstart_n) |=> ##[0:1] !o_power_on_oe_n;
  endproperty
  a_kick: assert property (p_kick) else $error("kickstart ignored");
  property p_dv1;
    $rose(i_power_fail_trip) |-> ##[1:3] o_divider_ctrl_bit1_set ##1 !o_divider_ctrl_bit1_set;
  endproperty
  a_dv1: assert property (p_dv1) else $error("divider request wrong");
  property p_wave_off;
    !i_power_fail_trip && !i_aux_supply |=> o_square_wave_oe_n && !o_square_wave_out;
  endproperty
  a_wave_off: assert property (p_wave_off) else $error("wave driven unpowered");
  property p_wave_drv;
    i_power_fail_trip |=> !o_square_wave_oe_n;
  endproperty
  a_wave_drv: assert property (p_wave_drv) else $error("wave undriven");
endmodule

bind rtc_pin_side_control rtc_pin_side_control_asserts rtc_pin_side_control_asserts_inst (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_power_fail_trip(i_power_fail_trip),
  .i_aux_supply(i_aux_supply), .i_cs_n(i_cs_n), .i_rd_n(i_rd_n),
  .i_kickstart_n(i_kickstart_n), .i_irq_flags(i_irq_flags), .i_irq_enables(i_irq_enables),
  .o_data_oe_n(o_data_oe_n), .o_irq_oe_n(o_irq_oe_n), .o_power_on_oe_n(o_power_on_oe_n),
  .o_divider_ctrl_bit1_set(o_divider_ctrl_bit1_set), .o_square_wave_out(o_square_wave_out),
  .o_square_wave_oe_n(o_square_wave_oe_n));

/* tb/rtc_pin_side_control_tb.sv */
// Self-checking bench for the pin-side control block.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module rtc_pin_side_control_tb;
  import rtc_pin_side_pkg::*;
  `define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, a, b); end end
  logic       clk, rst_n, trip, aux, ks_n, wake, off_req, ram_clear_n_n, square_wave_enable;
  logic       tick = 1'b0;
  logic       cs_n, rd_n, wr_n, bank1, doe_n, pon_n, pon_oe_n, irq_n, irq_oe_n;
  logic       dv1, wave, wave_oe_n, oe;
  logic [5:0] flags, ens;
  logic [3:0] rate;
  logic [1:0] tcnt = 2'h0;
  logic [7:0] addr, wdata, rdata, d;
  int         num_errors, samples_checked;
  initial clk = 1'b0;
  always #5 clk = ~clk;
  // oscillator tick every fourth cycle keeps divider runs short
  always @(negedge clk) begin
    tcnt <= tcnt + 2'h1;
    tick <= (tcnt == 2'h3);
  end
  rtc_host rtc_host_inst (.i_clock(clk), .i_rd_data(rdata), .i_data_oe_n(doe_n),
    .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_bank1(bank1), .o_addr(addr),
    .o_data(wdata));
  rtc_pin_side_control rtc_pin_side_control_inst (.i_clock(clk), .i_rst_n(rst_n),
    .i_power_fail_trip(trip), .i_aux_supply(aux), .i_cs_n(cs_n), .i_rd_n(rd_n),
    .i_wr_n(wr_n), .i_bank1(bank1), .i_addr(addr), .i_data(wdata), .o_data(rdata),
    .o_data_oe_n(doe_n), .i_kickstart_n(ks_n), .i_wakeup_irq(wake),
    .i_power_off_req(off_req), .o_power_on_out_n(pon_n), .o_power_on_oe_n(pon_oe_n),
    .i_irq_flags(flags), .i_irq_enables(ens), .o_irq_out_n(irq_n), .o_irq_oe_n(irq_oe_n),
    .i_ram_clear_n(ram_clear_n_n), .i_osc_tick(tick), .i_square_wave_enable(square_wave_enable),
    .i_rate_select(rate), .o_divider_ctrl_bit1_set(dv1), .o_square_wave_out(wave),
    .o_square_wave_oe_n(wave_oe_n));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic done(input string s);
    $display("test done: %s", s);
  endtask
  task automatic rd_chk(input logic b, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    logic       o;
    rtc_host_inst.read(b, a, v, o);
    `CHK(v, e)
    `CHK(o, 1'b0)
  endtask
  task automatic toggles(input int e);
    int   t;
    logic p;
    t = 0;
    cyc(4);
    p = wave;
    repeat (256) begin
      @(negedge clk);
      if (wave !== p) t++;
      p = wave;
    end
    `CHK(t, e)
    // a stuck unknown would count no toggles, so an idle wave must read low
    if (e == 0) `CHK(wave, 1'b0)
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // the whole sequence needs well under 10000 cycles
  initial begin
    #500000;
    num_errors++;
    summarize();
  end
  initial begin
    {rst_n, wake, off_req, square_wave_enable} = '0;
    {trip, aux, ks_n, ram_clear_n_n} = 4'hF;
    flags = 6'h00;
    ens = 6'h00;
    rate = 4'h0;
    cyc(2);
    rst_n = 1'b1;
    cyc(3);
    rd_chk(1'b1, 8'h4B, 8'h20);
    rtc_host_inst.write(1'b1, 8'h4B, 8'hFF);
    rd_chk(1'b1, 8'h4B, 8'hB0);
    rd_chk(1'b1, 8'h50, 8'h00);
    rtc_host_inst.write(1'b0, 8'h20, 8'h5A);
    rd_chk(1'b0, 8'h20, 8'h5A);
    done("registers");
    trip = 1'b0;
    rtc_host_inst.write(1'b0, 8'h20, 8'hA5);
    rtc_host_inst.read(1'b0, 8'h20, d, oe);
    `CHK(oe, 1'b1)
    trip = 1'b1;
    // the read opens two edges after power returns; the checker sees it refused in between
    rd_chk(1'b0, 8'h20, 8'h5A);
    `CHK(dv1, 1'b1)
    cyc(1);
    `CHK(dv1, 1'b0)
    done("power fail");
    ens = 6'h03;
    flags = 6'h03;
    cyc(2);
    `CHK(irq_oe_n, 1'b0)
    flags = 6'h02;
    cyc(2);
    `CHK(irq_oe_n, 1'b0)
    flags = 6'h00;
    cyc(2);
    `CHK(irq_oe_n, 1'b1)
    `CHK(irq_n, 1'b0)
    ks_n = 1'b0;
    cyc(3);
    `CHK(irq_oe_n, 1'b0)
    `CHK(pon_oe_n, 1'b1)
    ks_n = 1'b1;
    rd_chk(1'b1, 8'h4B, 8'hB1);
    rtc_host_inst.write(1'b1, 8'h4B, 8'hB0);
    cyc(2);
    `CHK(irq_oe_n, 1'b1)
    done("interrupt");
    trip = 1'b0;
    ks_n = 1'b0;
    cyc(3);
    `CHK(pon_oe_n, 1'b0)
    `CHK(pon_n, 1'b0)
    ks_n = 1'b1;
    off_req = 1'b1;
    cyc(1);
    off_req = 1'b0;
    cyc(2);
    `CHK(pon_oe_n, 1'b1)
    wake = 1'b1;
    cyc(1);
    wake = 1'b0;
    cyc(2);
    `CHK(pon_oe_n, 1'b0)
    trip = 1'b1;
    cyc(4);
    done("power pin");
    rtc_host_inst.write(1'b0, 8'h0E, 8'h00);
    rtc_host_inst.write(1'b0, 8'h7F, 8'h00);
    trip = 1'b0;
    ram_clear_n_n = 1'b0;
    cyc(1);
    ram_clear_n_n = 1'b1;
    trip = 1'b1;
    cyc(4);
    rd_chk(1'b0, 8'h0E, 8'hFF);
    rd_chk(1'b0, 8'h7F, 8'hFF);
    rd_chk(1'b1, 8'h4B, 8'hB0);
    done("ram clear");
    toggles(64);
    rtc_host_inst.write(1'b1, 8'h4B, 8'h90);
    square_wave_enable = 1'b1;
    for (int r = 0; r < 9; r++) begin
      rate = r[3:0];
      toggles(r < 3 ? 0 : 64 >> (r - 2));
    end
    square_wave_enable = 1'b0;
    toggles(0);
    `CHK(wave_oe_n, 1'b0)
    rtc_host_inst.write(1'b1, 8'h4B, 8'hB0);
    trip = 1'b0;
    toggles(64);
    aux = 1'b0;
    toggles(0);
    `CHK(wave_oe_n, 1'b1)
    done("square wave");
    summarize();
  end
endmodule
